// file: verilog/analog_input_scaler.sv
// scaling path for the analog input channels: normalize, then offset plus gain
// assumes converter samples and parameter writes are synchronous to clk
// Notes on behaviour
// RL1 - input voltage maps linearly: minus full scale is -100, plus full scale +100
// RL2 - scaled output equals offset plus gain times normalized value
// RL3 - offset comes from zero-order coefficient, gain from first-order coefficient
// RL4 - host computes gain from spans and offset from maximum values
// RL5 - host zeroes higher polynomial coefficients when no linearization wanted
// RL6 - report total and sensor-only channel counts; analog inputs are their difference
// RL7 - host takes scaled limits from position or force range parameters
// RL8 - unipolar zero to full scale range uses normalized limits 0 and +100
// RL9 - host sets scaling before using input as sensor or control source
// RL10 - coefficient writes are refused below command access level one
// RL11 - writes act on volatile copy; save command makes them persistent; the save image holds offset and gain only, not matrix coefficients
// RL12 - sensor-only channels serve motor and sensor sockets, not analog inputs
// RL13 - position-from-sensor values are input matrix coefficients per channel
// RL14 - signed fixed point wide enough; one scaled result per sample
`timescale 1ns/100ps
module analog_input_scaler
	import ain_scale_pkg::*;
#(
	parameter int ADC_W    = 16,
	parameter int NUM_CH   = NUM_CH_TOTAL,
	parameter int NUM_SENS = NUM_CH_SENSOR
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// converter sample stream for the selected analog input
	input  wire logic                        sample_valid,
	input  wire logic [2:0]                  sample_ch,
	input  wire logic signed [ADC_W-1:0]     sample_code,
	// parameter write port
	input  wire logic                        set_parameter_cmd,
	input  wire logic [2:0]                  par_ch,
	input  wire logic [31:0]                 par_id,
	input  wire logic [COEF_W-1:0]           par_value,
	input  wire logic [1:0]                  command_level_cmd,
	input  wire logic                        save_nonvolatile_cmd,
	// persistent store interface
	input  wire logic                        nv_load,
	input  wire logic [NUM_CH*2*COEF_W-1:0]  nv_image,
	output logic      [NUM_CH*2*COEF_W-1:0]  nv_save_image,
	output logic                             nv_save_stb,
	// scaled result
	output logic                             scaled_valid,
	output logic [2:0]                       scaled_ch,
	output logic signed [COEF_W-1:0]         scaled_value,
	// status
	output logic                             write_refused,
	output logic [3:0]                       num_inputs,
	output logic [3:0]                       num_sensor,
	output logic [3:0]                       num_analog,
	output logic [NUM_CH*COEF_W-1:0]         pos_matrix
);
	import ain_scale_pkg::*;

	logic [COEF_W-1:0]         offset_q [NUM_CH];
	logic [COEF_W-1:0]         gain_q   [NUM_CH];
	logic [COEF_W-1:0]         matrix_q [NUM_CH];
	logic                      norm_valid;
	logic signed [COEF_W-1:0]  norm_val;
	logic [2:0]                ch_q1;
	logic                      coef_id;
	logic                      poly_id;
	logic                      matrix_id;
	logic                      level_ok;
	logic signed [2*COEF_W-1:0] prod;
	logic signed [2*COEF_W-1:0] sum;
	logic signed [2*COEF_W-1:0] sat_hi;
	logic signed [2*COEF_W-1:0] sat_lo;

	// RL1 normalize sample
	ain_norm #(
		.ADC_W (ADC_W)
	) ain_norm_inst (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (sample_valid),
		.in_code   (sample_code),
		.out_valid (norm_valid),
		.out_norm  (norm_val)
	);

	// channel rides beside the normalize stage so result and index stay paired
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ch_q1 <= '0;
		else if (sample_valid)
			ch_q1 <= sample_ch;
	end

	// RL10 level gate
	assign level_ok = (command_level_cmd >= LEVEL_COEF);
	assign coef_id  = (par_id == PID_OFFSET) || (par_id == PID_GAIN);
	// higher orders are held at zero here; writes at level one or above are accepted but not stored
	assign poly_id  = (par_id == PID_POLY2) || (par_id == PID_POLY3) || (par_id == PID_POLY4);
	// one matrix id per channel; every one of them is gated, not only the first
	assign matrix_id = (par_id >= PID_POS_SENSOR) && (par_id < PID_POS_SENSOR + 32'(NUM_CH));

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			// RL3 coefficient store
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					offset_q[g] <= '0;
					gain_q[g]   <= GAIN_RESET;
				end else if (nv_load) begin
					offset_q[g] <= nv_image[(2*g)*COEF_W +: COEF_W];
					gain_q[g]   <= nv_image[(2*g+1)*COEF_W +: COEF_W];
				end else if (set_parameter_cmd && level_ok && par_ch == 3'(g)) begin
					// RL11 volatile write
					if (par_id == PID_OFFSET)
						offset_q[g] <= par_value;
					if (par_id == PID_GAIN)
						gain_q[g] <= par_value;
				end
			end
			// RL13 input matrix coefficient
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					matrix_q[g] <= '0;
				else if (set_parameter_cmd && level_ok && par_id == PID_POS_SENSOR + 32'(g))
					matrix_q[g] <= par_value;
			end
			// RL11 save image
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					nv_save_image[2*g*COEF_W +: 2*COEF_W] <= '0;
				else if (save_nonvolatile_cmd)
					nv_save_image[2*g*COEF_W +: 2*COEF_W] <= {gain_q[g], offset_q[g]};
			end
			// extra stage keeps the output a plain flop; matrix reads lag writes by one edge
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					pos_matrix[g*COEF_W +: COEF_W] <= '0;
				else
					pos_matrix[g*COEF_W +: COEF_W] <= matrix_q[g];
			end
		end
	endgenerate

	// strobe lags the command by one edge, when the image is already captured
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			nv_save_stb <= 1'b0;
		else
			nv_save_stb <= save_nonvolatile_cmd;
	end

	// RL10 refusal flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			write_refused <= 1'b0;
		else
			write_refused <= set_parameter_cmd && !level_ok
				&& (coef_id || poly_id || matrix_id);
	end

	// RL2 offset plus gain times normalized, q16.16 product rescaled
	// RL14 wide product then saturation, one result per sample
	assign prod   = $signed(gain_q[ch_q1]) * norm_val;
	assign sum    = (prod >>> FRAC_W) + $signed({{COEF_W{offset_q[ch_q1][COEF_W-1]}}, offset_q[ch_q1]});
	assign sat_hi = $signed({{(COEF_W+1){1'b0}}, {(COEF_W-1){1'b1}}});
	assign sat_lo = -sat_hi - 64'sd1;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scaled_valid <= 1'b0;
			scaled_value <= '0;
			scaled_ch    <= '0;
		end else begin
			scaled_valid <= norm_valid;
			// value and channel hold between results so a late reader still sees them
			if (norm_valid) begin
				scaled_ch <= ch_q1;
				if (sum > sat_hi)
					scaled_value <= sat_hi[COEF_W-1:0];
				else if (sum < sat_lo)
					scaled_value <= sat_lo[COEF_W-1:0];
				else
					scaled_value <= sum[COEF_W-1:0];
			end
		end
	end

	// RL6 channel counts
	// RL12 sensor channels excluded
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			num_inputs <= '0;
			num_sensor <= '0;
			num_analog <= '0;
		end else begin
			num_inputs <= 4'(NUM_CH);
			num_sensor <= 4'(NUM_SENS);
			num_analog <= 4'(NUM_CH - NUM_SENS);
		end
	end
endmodule // analog_input_scaler

// file: include/ain_scale_pkg.sv
// constants for the analog input scaling path
// assumes signed two's complement converter codes and a host-side parameter write port
package ain_scale_pkg;
	// parameter identifiers as written by set_parameter_cmd
	localparam logic [31:0] PID_OFFSET     = 32'h02000200;
	localparam logic [31:0] PID_GAIN       = 32'h02000300;
	localparam logic [31:0] PID_POLY2      = 32'h02000400;
	localparam logic [31:0] PID_POLY3      = 32'h02000500;
	localparam logic [31:0] PID_POLY4      = 32'h02000600;
	localparam logic [31:0] PID_POS_SENSOR = 32'h07000500;
	localparam logic [31:0] PID_NUM_INPUTS = 32'h0E000B00;
	localparam logic [31:0] PID_NUM_SENSOR = 32'h0E000B03;
	// normalized full scale, plus and minus one hundred
	localparam int NORM_FULL     = 100;
	// fixed point: coefficients are q16.16, outputs q16.16
	localparam int COEF_W        = 32;
	localparam int FRAC_W        = 16;
	// access level needed for coefficient writes
	localparam logic [1:0] LEVEL_COEF = 2'h1;
	// channel counts
	localparam int NUM_CH_TOTAL  = 6;
	localparam int NUM_CH_SENSOR = 4;
	// reset value of the gain: 1.0 in q16.16
	localparam logic [31:0] GAIN_RESET = 32'h00010000;
endpackage

// file: verilog/ain_norm.sv
// converts a signed converter code into a normalized q16.16 value
// assumes codes are two's complement and full scale maps to plus or minus one hundred
`timescale 1ns/100ps
module ain_norm
	import ain_scale_pkg::*;
#(
	parameter int ADC_W = 16
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// sample in
	input  wire logic                     in_valid,
	input  wire logic signed [ADC_W-1:0]  in_code,
	// normalized out
	output logic                          out_valid,
	output logic signed [COEF_W-1:0]      out_norm
);
	// full scale code is 2^(ADC_W-1); times 100 then rescaled to q16.16
	localparam int SHIFT = ADC_W - 1 - FRAC_W;
	logic signed [ADC_W+7:0] prod;

	assign prod = in_code * $signed(8'(NORM_FULL));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			out_norm  <= '0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				if (SHIFT >= 0)
					out_norm <= COEF_W'(prod >>> SHIFT);
				else
					out_norm <= COEF_W'(prod) <<< (-SHIFT);
			end
		end
	end
endmodule // ain_norm

// file: tb/scaler_monitor.sv
// checker on the scaler top ports
// assumes ain_scale_pkg is compiled first
`timescale 1ns/100ps
module scaler_checker
	import ain_scale_pkg::*;
#(
	parameter int NUM_CH   = 6,
	parameter int NUM_SENS = 4
) (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rstn,
	// samples and writes
	input wire logic                     sample_valid,
	input wire logic [2:0]               sample_ch,
	input wire logic                     set_parameter_cmd,
	input wire logic [31:0]              par_id,
	input wire logic [1:0]               command_level_cmd,
	input wire logic                     save_nonvolatile_cmd,
	// results
	input wire logic                     scaled_valid,
	input wire logic [2:0]               scaled_ch,
	input wire logic                     nv_save_stb,
	input wire logic                     write_refused,
	input wire logic [3:0]               num_inputs,
	input wire logic [3:0]               num_sensor,
	input wire logic [3:0]               num_analog
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_lat; sample_valid |-> ##2 scaled_valid; endproperty
	property p_ch; sample_valid |-> ##2 scaled_ch == $past(sample_ch, 2); endproperty
	property p_idle; !sample_valid |-> ##2 !scaled_valid; endproperty
	property p_ref; set_parameter_cmd && command_level_cmd == 2'h0 && par_id == PID_GAIN |=> write_refused; endproperty
	property p_ok; set_parameter_cmd && command_level_cmd >= LEVEL_COEF |=> !write_refused; endproperty
	property p_stb; save_nonvolatile_cmd |=> nv_save_stb; endproperty
	property p_cnt; num_analog == num_inputs - num_sensor; endproperty
	// counts settle one edge after release
	property p_fix; $past(rstn) |-> num_inputs == NUM_CH && num_sensor == NUM_SENS; endproperty
	a_lat: assert property (p_lat) else $error("late result");
	a_ch: assert property (p_ch) else $error("wrong result channel");
	a_idle: assert property (p_idle) else $error("result without sample");
	a_ref: assert property (p_ref) else $error("low level write taken");
	a_ok: assert property (p_ok) else $error("legal write refused");
	a_stb: assert property (p_stb) else $error("no save strobe");
	a_cnt: assert property (p_cnt) else $error("analog count wrong");
	a_fix: assert property (p_fix) else $error("channel counts wrong");
	c_res: cover property (scaled_valid);
	c_ref: cover property (write_refused);
	c_save: cover property (nv_save_stb);
endmodule // scaler_checker

bind analog_input_scaler scaler_checker #(.NUM_CH(NUM_CH), .NUM_SENS(NUM_SENS)) scaler_checker_inst (
	.clk, .rstn, .sample_valid, .sample_ch, .set_parameter_cmd, .par_id, .command_level_cmd,
	.save_nonvolatile_cmd, .scaled_valid, .scaled_ch, .nv_save_stb, .write_refused,
	.num_inputs, .num_sensor, .num_analog);

// file: tb/src_model.sv
// analog source model: one converter sample per request
// assumes requests arrive on the rising edge
`timescale 1ns/100ps
module src_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// request from bench
	input  wire logic        req,
	input  wire logic [2:0]  req_ch,
	input  wire logic [15:0] req_code,
	// converter side
	output logic             sample_valid,
	output logic [2:0]       sample_ch,
	output logic [15:0]      sample_code
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sample_valid <= 1'b0;
			sample_ch    <= 3'h0;
			sample_code  <= 16'h0;
		end else begin
			sample_valid <= req;
			sample_ch    <= req_ch;
			// idle code flips so stale data is never reused
			sample_code  <= req ? req_code : ~sample_code;
		end
	end
endmodule // src_model

// file: tb/analog_input_scaler_tb.sv
// self-checking bench for analog_input_scaler
// assumes src_model feeds samples and default channel counts
`timescale 1ns/100ps
module analog_input_scaler_tb;
	import ain_scale_pkg::*;
	logic         clk, rstn, req, sv, set_parameter_cmd, save_nonvolatile_cmd, nv_load;
	logic         scaled_valid, nv_save_stb, write_refused;
	logic [1:0]   command_level_cmd;
	logic [2:0]   rch, sc, par_ch, scaled_ch;
	logic [3:0]   num_inputs, num_sensor, num_analog;
	logic [15:0]  rcode, scode;
	logic [31:0]  par_id, par_value, scaled_value;
	logic [191:0] pos_matrix;
	logic [383:0] nv_save_image, nv_image;
	int           err_total = 0, checks_done = 0, cyc = 0;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	src_model src_model_inst (.clk, .rstn, .req, .req_ch(rch), .req_code(rcode),
		.sample_valid(sv), .sample_ch(sc), .sample_code(scode));
	analog_input_scaler analog_input_scaler_inst (.clk, .rstn, .sample_valid(sv), .sample_ch(sc),
		.sample_code(scode), .set_parameter_cmd, .par_ch, .par_id, .par_value, .command_level_cmd,
		.save_nonvolatile_cmd, .nv_load, .nv_image, .nv_save_image, .nv_save_stb,
		.scaled_valid, .scaled_ch, .scaled_value, .write_refused, .num_inputs, .num_sensor,
		.num_analog, .pos_matrix);
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic conclude;
		if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(logic [1:0] l, logic [2:0] c, logic [31:0] id, logic [31:0] v);
		@(posedge clk);
		command_level_cmd <= l;
		set_parameter_cmd <= 1'b1;
		par_ch <= c;
		par_id <= id;
		par_value <= v;
		@(posedge clk);
		set_parameter_cmd <= 1'b0;
		@(negedge clk);
	endtask
	task automatic smp(logic [2:0] c, logic [15:0] code, logic [31:0] e);
		int i;
		@(posedge clk);
		req <= 1'b1;
		rch <= c;
		rcode <= code;
		@(posedge clk);
		req <= 1'b0;
		for (i = 0; i < 8 && scaled_valid !== 1'b1; i++) @(negedge clk);
		chk("scaled_valid", 32'h1, {31'h0, scaled_valid});
		chk("scaled_ch", {29'h0, c}, {29'h0, scaled_ch});
		chk("scaled_value", e, scaled_value);
	endtask
	task automatic t_norm;
		smp(3'h4, 16'h8000, 32'hff9c0000);
		smp(3'h4, 16'h0000, 32'h00000000);
		smp(3'h4, 16'h4000, 32'h00320000);
	endtask
	task automatic t_refuse;
		wr(2'h0, 3'h4, PID_GAIN, 32'h00020000);
		chk("write_refused", 32'h1, {31'h0, write_refused});
		smp(3'h4, 16'h4000, 32'h00320000);
	endtask
	// span 0..100 over full input: gain 0.5, offset 50
	task automatic t_scale;
		wr(2'h1, 3'h5, PID_OFFSET, 32'h00320000);
		wr(2'h1, 3'h5, PID_GAIN, 32'h00008000);
		wr(2'h1, 3'h5, PID_POLY2, 32'h0);
		wr(2'h1, 3'h5, PID_POLY3, 32'h0);
		wr(2'h1, 3'h5, PID_POLY4, 32'h0);
		smp(3'h5, 16'h8000, 32'h00000000);
		smp(3'h5, 16'h4000, 32'h004b0000);
	endtask
	// position limits -20..180 over unipolar normalized 0..100: gain 2, offset -20
	task automatic t_unipolar;
		wr(2'h1, 3'h3, PID_OFFSET, 32'hffec0000);
		wr(2'h1, 3'h3, PID_GAIN, 32'h00020000);
		smp(3'h3, 16'h0000, 32'hffec0000);
		smp(3'h3, 16'h4000, 32'h00500000);
	endtask
	// image puts offset 1.0 and gain 2.0 on channel 2, zero elsewhere
	task automatic t_load;
		@(posedge clk);
		nv_image <= {192'h0, 32'h00020000, 32'h00010000, 128'h0};
		nv_load <= 1'b1;
		@(posedge clk);
		nv_load <= 1'b0;
		smp(3'h2, 16'h4000, 32'h00650000);
	endtask
	task automatic t_save;
		@(posedge clk);
		save_nonvolatile_cmd <= 1'b1;
		@(posedge clk);
		save_nonvolatile_cmd <= 1'b0;
		@(negedge clk);
		chk("nv_save_stb", 32'h1, {31'h0, nv_save_stb});
		chk("nv_offset5", 32'h00320000, nv_save_image[320+:32]);
		chk("nv_gain4", 32'h00010000, nv_save_image[288+:32]);
	endtask
	task automatic t_misc;
		chk("num_inputs", 32'h6, {28'h0, num_inputs});
		chk("num_sensor", 32'h4, {28'h0, num_sensor});
		chk("num_analog", 32'h2, {28'h0, num_analog});
		wr(2'h1, 3'h0, PID_POS_SENSOR + 32'h1, 32'h00010000);
		@(negedge clk);
		chk("pos_matrix1", 32'h00010000, pos_matrix[32+:32]);
		wr(2'h0, 3'h0, PID_POS_SENSOR + 32'h3, 32'h00010000);
		chk("write_refused", 32'h1, {31'h0, write_refused});
		@(negedge clk);
		chk("pos_matrix3", 32'h0, pos_matrix[96+:32]);
	endtask
	initial begin
		rstn = 1'b0;
		req = 1'b0;
		rch = 3'h0;
		rcode = 16'h0;
		set_parameter_cmd = 1'b0;
		save_nonvolatile_cmd = 1'b0;
		command_level_cmd = 2'h0;
		par_ch = 3'h0;
		par_id = 32'h0;
		par_value = 32'h0;
		nv_load = 1'b0;
		nv_image = 384'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_norm;
		t_refuse;
		t_scale;
		t_unipolar;
		t_save;
		t_misc;
		t_load;
		conclude;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total++;
			conclude;
		end
	end
endmodule // analog_input_scaler_tb
